// >>> rtl/efvu_pkg.sv
package efvu_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_VBR = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_ISTS = 8'h08;
  localparam logic [7:0] ADDR_IMASK = 8'h0C;
  localparam logic [7:0] ADDR_LAST = 8'h10;

  localparam logic [31:0] VBR_RST = 32'h0000_0000;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [2:0] IMASK_RST = 3'h0;
  localparam int VBR_LSB = 20;

  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RSVD = 1;
  localparam int IRQ_INTERRUPT_ACKNOWLEDGE_CYCLE = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Vector numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_ACCESS = 8'h02;
  localparam logic [7:0] VEC_ADDRESS = 8'h03;
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] VEC_DIVZERO = 8'h05;
  localparam logic [7:0] VEC_PRIV = 8'h08;
  localparam logic [7:0] VEC_TRACE = 8'h09;
  localparam logic [7:0] VEC_LINEA = 8'h0A;
  localparam logic [7:0] VEC_LINEF = 8'h0B;
  localparam logic [7:0] VEC_DEBUG = 8'h0C;
  localparam logic [7:0] VEC_FORMAT = 8'h0E;
  localparam logic [7:0] VEC_UNINIT = 8'h0F;
  localparam logic [7:0] VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] VEC_TRAP_LO = 8'h20;
  localparam logic [7:0] VEC_TRAP_HI = 8'h2F;
  localparam logic [7:0] VEC_UNSUPP = 8'h3D;
  localparam logic [7:0] VEC_USER_LO = 8'h40;

  // ----------------------------------------------------------------
  // Frame and status word layout
  // ----------------------------------------------------------------
  localparam logic [1:0] FMT_HI = 2'h1;
  localparam logic [31:0] FRAME_BYTES = 32'h0000_0008;
  localparam logic [31:0] PC_SLOT = 32'h0000_0004;
  localparam logic [3:0] FS_NONE = 4'h0;
  localparam logic [3:0] FS_IFETCH = 4'h4;
  localparam logic [3:0] FS_OPWR = 4'h8;
  localparam logic [3:0] FS_WPROT = 4'h9;
  localparam logic [3:0] FS_OPRD = 4'hC;
  localparam int SR_TRACE = 15;
  localparam int SR_SUPER = 13;
  localparam int SR_MASTER = 12;
  localparam int SR_MASK_LSB = 8;

  // Acknowledge space address: upper bits fixed, level in bits 4:2
  localparam logic [26:0] INTERRUPT_ACKNOWLEDGE_CYCLE_ADDR_HI = 27'h7FF_FFFF;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_INTERRUPT_ACKNOWLEDGE_CYCLE = 6'b00_0010,
    ST_WR_PC = 6'b00_0100,
    ST_WR_FV = 6'b00_1000,
    ST_FETCH = 6'b01_0000,
    ST_DONE = 6'b10_0000
  } efvu_state_e;

endpackage

// >>> rtl/efvu_vec_class.sv
`timescale 1ns/1ps
module efvu_vec_class
  import efvu_pkg::*;
(
  input wire logic [7:0] vec_in,
  output logic stack_next_out,
  output logic reserved_out
);

  wire is_fault;
  wire is_next;

  assign is_fault = (vec_in == VEC_ACCESS) || (vec_in == VEC_ADDRESS) || (vec_in == VEC_ILLEGAL) ||
                    (vec_in == VEC_DIVZERO) || (vec_in == VEC_PRIV) || (vec_in == VEC_LINEA) ||
                    (vec_in == VEC_LINEF) || (vec_in == VEC_FORMAT) || (vec_in == VEC_UNSUPP);
  assign is_next = (vec_in >= VEC_USER_LO) || (vec_in == VEC_TRACE) || (vec_in == VEC_DEBUG) ||
                   (vec_in == VEC_UNINIT) || ((vec_in >= VEC_SPURIOUS) && (vec_in <= VEC_TRAP_HI));
  assign stack_next_out = is_next;
  assign reserved_out = !is_fault && !is_next;

endmodule

// >>> rtl/efvu_top.sv
`timescale 1ns/1ps
module efvu_top
  import efvu_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic irq_out,
  // Pipeline side
  input wire logic exc_req_in,
  input wire logic exc_is_irq_in,
  input wire logic [7:0] exc_vector_in,
  input wire logic [2:0] irq_level_in,
  input wire logic [31:0] fault_pc_in,
  input wire logic [31:0] next_pc_in,
  input wire logic [15:0] status_word_in,
  input wire logic [31:0] system_stack_pointer_in,
  input wire logic [3:0] fault_status_field_in,
  input wire logic debug_interrupted_in,
  input wire logic insn_retire_in,
  output logic exc_ready_out,
  output logic [15:0] status_word_out,
  output logic [31:0] system_stack_pointer_out,
  output logic [31:0] handler_pc_out,
  output logic handler_fetch_out,
  output logic irq_inhibit_out,
  // Memory bus master
  output logic mem_req_out,
  output logic mem_we_out,
  output logic interrupt_acknowledge_cycle_out,
  output logic [31:0] mem_addr_out,
  output logic [31:0] mem_wdata_out,
  input wire logic mem_ack_in,
  input wire logic mem_autovec_in,
  input wire logic mem_err_in,
  input wire logic [31:0] mem_rdata_in
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [11:0] vbr_hi_ff;
  logic ctrl_en_ff;
  logic [2:0] ists_ff, imask_ff;
  logic [7:0] last_vec_ff;
  logic [3:0] last_fmt_ff;

  wire aw_hs = s_axi_awvalid_in && s_axi_awready_out;
  wire w_hs = s_axi_wvalid_in && s_axi_wready_out;
  wire ar_hs = s_axi_arvalid_in && s_axi_arready_out;
  wire wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
  wire wr_vbr = wr_go && (awaddr_ff == ADDR_VBR);
  wire wr_ctrl = wr_go && (awaddr_ff == ADDR_CTRL);
  wire wr_imask = wr_go && (awaddr_ff == ADDR_IMASK);
  wire wr_ok = wr_vbr || wr_ctrl || wr_imask || (awaddr_ff == ADDR_ISTS) || (awaddr_ff == ADDR_LAST);
  wire rd_ists = ar_hs && (s_axi_araddr_in == ADDR_ISTS);
  wire rd_map = (s_axi_araddr_in <= ADDR_LAST) && (s_axi_araddr_in[1:0] == 2'b00);
  wire [31:0] vbr_word = {vbr_hi_ff, 20'h0_0000};
  wire [31:0] rd_mux = (s_axi_araddr_in == ADDR_VBR) ? vbr_word :
                       (s_axi_araddr_in == ADDR_CTRL) ? {31'h0, ctrl_en_ff} :
                       (s_axi_araddr_in == ADDR_ISTS) ? {29'h0, ists_ff} :
                       (s_axi_araddr_in == ADDR_IMASK) ? {29'h0, imask_ff} :
                       (s_axi_araddr_in == ADDR_LAST) ? {20'h0_0000, last_fmt_ff, last_vec_ff} : 32'h0000_0000;
  wire [11:0] nxt_vbr_hi = {wstrb_ff[3] ? wdata_ff[31:24] : vbr_hi_ff[11:4],
                            wstrb_ff[2] ? wdata_ff[23:20] : vbr_hi_ff[3:0]};

  assign s_axi_awready_out = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready_out = !w_held_ff && !bvalid_ff;
  assign s_axi_arready_out = !rvalid_ff;
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rdata_out = rdata_ff;
  assign s_axi_rresp_out = rresp_ff;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr_in;
      end else if (wr_go) begin
        aw_held_ff <= 1'b0;
      end
      if (w_hs) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_in;
        wstrb_ff <= s_axi_wstrb_in;
      end else if (wr_go) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else begin
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        bvalid_ff <= 1'b0;
      end
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready_in) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Exception sequencer
  // ----------------------------------------------------------------
  efvu_state_e state_ff, nxt_state;
  logic [7:0] vec_ff;
  logic is_irq_ff;
  logic [2:0] level_ff;
  logic [31:0] pc_ff, orig_sp_ff;
  logic [15:0] sr_ff;
  logic [3:0] fs_ff;
  logic debug_int_ff;

  wire stack_next;
  wire vec_reserved;
  wire [7:0] class_vec = (state_ff == ST_IDLE) ? exc_vector_in : vec_ff;
  efvu_vec_class u_class (
    .vec_in(class_vec),
    .stack_next_out(stack_next),
    .reserved_out(vec_reserved)
  );

  wire [31:0] frame_sp = {orig_sp_ff[31:2], 2'b00} - FRAME_BYTES;
  wire [3:0] fmt_field = {FMT_HI, orig_sp_ff[1:0]};
  wire fs_allowed = (vec_ff == VEC_ACCESS) || (vec_ff == VEC_ADDRESS) || debug_int_ff;
  wire fs_defined = (fs_ff == FS_IFETCH) || (fs_ff == FS_OPWR) || (fs_ff == FS_WPROT) || (fs_ff == FS_OPRD);
  wire [3:0] fs_field = (fs_allowed && fs_defined) ? fs_ff : FS_NONE;
  wire [31:0] fv_word = {fmt_field, fs_field[3:2], vec_ff, fs_field[1:0], sr_ff};
  wire [31:0] vec_addr = {vbr_hi_ff, 10'h000, vec_ff, 2'b00};
  wire [7:0] interrupt_acknowledge_cycle_vec = mem_err_in ? VEC_SPURIOUS :
                        mem_autovec_in ? (VEC_SPURIOUS + {5'h00, level_ff}) : mem_rdata_in[7:0];
  wire [15:0] entry_sr = {1'b0, sr_ff[14], 1'b1, is_irq_ff ? 1'b0 : sr_ff[SR_MASTER], 1'b0,
                          is_irq_ff ? level_ff : sr_ff[10:8], sr_ff[7:0]};
  wire take = exc_ready_out && exc_req_in;

  assign exc_ready_out = (state_ff == ST_IDLE) && ctrl_en_ff && !(exc_is_irq_in && irq_inhibit_out);
  assign mem_req_out = (state_ff == ST_INTERRUPT_ACKNOWLEDGE_CYCLE) || (state_ff == ST_WR_PC) || (state_ff == ST_WR_FV) ||
                       (state_ff == ST_FETCH);
  assign mem_we_out = (state_ff == ST_WR_PC) || (state_ff == ST_WR_FV);
  assign interrupt_acknowledge_cycle_out = (state_ff == ST_INTERRUPT_ACKNOWLEDGE_CYCLE);
  assign mem_addr_out = (state_ff == ST_INTERRUPT_ACKNOWLEDGE_CYCLE) ? {INTERRUPT_ACKNOWLEDGE_CYCLE_ADDR_HI, level_ff, 2'b00} :
                        (state_ff == ST_WR_PC) ? (frame_sp + PC_SLOT) :
                        (state_ff == ST_WR_FV) ? frame_sp : vec_addr;
  assign mem_wdata_out = (state_ff == ST_WR_PC) ? pc_ff : fv_word;
  assign handler_fetch_out = (state_ff == ST_DONE);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = take ? (exc_is_irq_in ? ST_INTERRUPT_ACKNOWLEDGE_CYCLE : ST_WR_PC) : ST_IDLE;
      ST_INTERRUPT_ACKNOWLEDGE_CYCLE: nxt_state = (mem_ack_in || mem_err_in) ? ST_WR_PC : ST_INTERRUPT_ACKNOWLEDGE_CYCLE;
      ST_WR_PC: nxt_state = mem_ack_in ? ST_WR_FV : ST_WR_PC;
      ST_WR_FV: nxt_state = mem_ack_in ? ST_FETCH : ST_WR_FV;
      ST_FETCH: nxt_state = mem_ack_in ? ST_DONE : ST_FETCH;
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_IDLE;
      vec_ff <= 8'h00;
      is_irq_ff <= 1'b0;
      level_ff <= 3'h0;
      pc_ff <= 32'h0000_0000;
      orig_sp_ff <= 32'h0000_0000;
      sr_ff <= 16'h0000;
      fs_ff <= FS_NONE;
      debug_int_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (take) begin
        vec_ff <= exc_vector_in;
        is_irq_ff <= exc_is_irq_in;
        level_ff <= irq_level_in;
        pc_ff <= (!exc_is_irq_in && !stack_next && !vec_reserved) ? fault_pc_in : next_pc_in;
        orig_sp_ff <= system_stack_pointer_in;
        sr_ff <= status_word_in;
        fs_ff <= fault_status_field_in;
        debug_int_ff <= debug_interrupted_in;
      end
      if ((state_ff == ST_INTERRUPT_ACKNOWLEDGE_CYCLE) && (mem_ack_in || mem_err_in)) begin
        vec_ff <= interrupt_acknowledge_cycle_vec;
      end
    end
  end

  // ----------------------------------------------------------------
  // Results to the pipeline
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_word_out <= 16'h0000;
      system_stack_pointer_out <= 32'h0000_0000;
      handler_pc_out <= 32'h0000_0000;
      irq_inhibit_out <= 1'b0;
      last_vec_ff <= 8'h00;
      last_fmt_ff <= 4'h0;
    end else begin
      if ((state_ff == ST_FETCH) && mem_ack_in) begin
        handler_pc_out <= mem_rdata_in;
        status_word_out <= entry_sr;
        system_stack_pointer_out <= frame_sp;
        last_vec_ff <= vec_ff;
        last_fmt_ff <= fmt_field;
      end
      if (state_ff == ST_DONE) begin
        irq_inhibit_out <= 1'b1;
      end else if (insn_retire_in) begin
        irq_inhibit_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration and interrupt registers
  // ----------------------------------------------------------------
  wire [2:0] ev_set = {(state_ff == ST_INTERRUPT_ACKNOWLEDGE_CYCLE) && (mem_ack_in || mem_err_in),
                       (state_ff == ST_FETCH) && mem_ack_in && vec_reserved, state_ff == ST_DONE};
  wire [2:0] ists_clr = rd_ists ? 3'h7 : 3'h0;
  assign irq_out = |(ists_ff & imask_ff);

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vbr_hi_ff <= VBR_RST[31:VBR_LSB];
      ctrl_en_ff <= CTRL_EN_RST;
      imask_ff <= IMASK_RST;
      ists_ff <= 3'h0;
    end else begin
      if (wr_vbr) begin
        vbr_hi_ff <= nxt_vbr_hi;
      end
      if (wr_ctrl && wstrb_ff[0]) begin
        ctrl_en_ff <= wdata_ff[0];
      end
      if (wr_imask && wstrb_ff[0]) begin
        imask_ff <= wdata_ff[2:0];
      end
      ists_ff <= (ists_ff & ~ists_clr) | ev_set;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  AST_SP_ENTRY: assert property ((state_ff == ST_FETCH) && mem_ack_in |=>
    system_stack_pointer_out == ({orig_sp_ff[31:2], 2'b00} - FRAME_BYTES)) else $error("stack pointer wrong");
  AST_FORMAT: assert property ((state_ff == ST_WR_FV) |->
    mem_wdata_out[31:28] == (4'h4 + {2'b00, orig_sp_ff[1:0]})) else $error("format field wrong");
  AST_VEC_ADDR: assert property ((state_ff == ST_FETCH) |->
    mem_addr_out == ({vbr_hi_ff, 20'h0_0000} + {22'h00_0000, vec_ff, 2'b00})) else $error("vector address wrong");
  AST_PC_SLOT: assert property ((state_ff == ST_WR_PC) |->
    mem_we_out && mem_addr_out[1:0] == 2'b00 && mem_addr_out == orig_sp_ff - {30'h0, orig_sp_ff[1:0]} - 32'h4)
    else $error("pc slot wrong");
  AST_INHIBIT: assert property (handler_fetch_out ##1 !insn_retire_in |=> irq_inhibit_out)
    else $error("interrupt sampling not held off");
  AST_SR_ENTRY: assert property ((state_ff == ST_DONE) |-> status_word_out[SR_SUPER] &&
    !status_word_out[SR_TRACE] && (!is_irq_ff || status_word_out[10:8] == level_ff)) else $error("status word wrong");
  AST_INTERRUPT_ACKNOWLEDGE_CYCLE: assert property ($rose(interrupt_acknowledge_cycle_out) |-> !mem_we_out &&
    mem_addr_out[4:2] == level_ff && $past(exc_is_irq_in)) else $error("acknowledge cycle wrong");
  AST_FS: assert property ((state_ff == ST_WR_FV) && !debug_int_ff && vec_ff != VEC_ACCESS &&
    vec_ff != VEC_ADDRESS |-> {mem_wdata_out[27:26], mem_wdata_out[17:16]} == 4'h0) else $error("fault status set");
  AST_DONE_FETCH: assert property ((state_ff == ST_FETCH) && mem_ack_in |=> handler_fetch_out ##1
    (state_ff == ST_IDLE) && irq_inhibit_out) else $error("completion sequence wrong");

endmodule

// >>> verification/efvu_mem_model.sv
`timescale 1ns/1ps
// ----
// Memory bus and interrupting peripheral
// ----
module efvu_mem_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic ack_cyc_in,
  input wire logic [31:0] addr_in,
  input wire logic [1:0] delay_in,
  input wire logic [1:0] mode_in,
  input wire logic [7:0] vec_in,
  output logic ack_out,
  output logic autovec_out,
  output logic err_out,
  output logic [31:0] rdata_out
);
  logic [1:0] wait_ff;
  logic busy;
  logic fail;
  assign busy = req_in && !ack_out && !err_out;
  assign fail = ack_cyc_in && mode_in == 2'h2;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      autovec_out <= 1'b0;
      err_out <= 1'b0;
      wait_ff <= 2'h0;
      rdata_out <= 32'h5A5A_A5A5;
    end else if (!busy || wait_ff != delay_in) begin
      // Idle data lines toggle so a stale value never passes
      ack_out <= 1'b0;
      autovec_out <= 1'b0;
      err_out <= 1'b0;
      wait_ff <= busy ? wait_ff + 2'h1 : 2'h0;
      rdata_out <= ~rdata_out;
    end else begin
      ack_out <= !fail;
      err_out <= fail;
      autovec_out <= ack_cyc_in && mode_in == 2'h1;
      // Table entry content is the inverted fetch address
      rdata_out <= ack_cyc_in ? {rdata_out[31:8], vec_in} : (we_in ? rdata_out : ~addr_in);
    end
  end
endmodule

// >>> verification/efvu_top_tb.sv
`timescale 1ns/1ps
module efvu_top_tb
  import efvu_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic req = 1'b0, isi = 1'b0, dbg = 1'b0, ret = 1'b0;
  logic awr, wrd, bv, arr, rv, irq, rdy, hf, inh, mreq, mwe, mcyc, ack, av, merr;
  logic [7:0] awa = 8'h00, ara = 8'h00, vec = 8'h00, mvec = 8'h00;
  logic [2:0] lvl = 3'h0;
  logic [1:0] dly = 2'h0, md = 2'h0, bresp, rresp;
  logic [3:0] fs = 4'h0, ws = 4'hF;
  logic [15:0] sr = 16'h9F1F, sr_o;
  logic [31:0] wd = 32'h0, fpc = 32'h0000_1000, npc = 32'h0000_1004, ssp = 32'h0, vbr = 32'h0;
  logic [31:0] rdat, ssp_o, hpc, maddr, mwd, mrd, ra, ia;
  logic [31:0] wa [2];
  logic [31:0] wdv [2];
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  localparam logic [7:0] VL [20] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C,
    8'h0D, 8'h0E, 8'h0F, 8'h18, 8'h20, 8'h2F, 8'h3D, 8'h40, 8'h80, 8'hFF};
  localparam logic [3:0] FSL [5] = '{4'h4, 4'h8, 4'h9, 4'hC, 4'h1};

  always #2 clk = ~clk;

  efvu_top i_efvu_top (
    .clk_sys_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(brd), .s_axi_araddr_in(ara),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rrd), .irq_out(irq), .exc_req_in(req), .exc_is_irq_in(isi),
    .exc_vector_in(vec), .irq_level_in(lvl), .fault_pc_in(fpc), .next_pc_in(npc), .status_word_in(sr),
    .system_stack_pointer_in(ssp), .fault_status_field_in(fs), .debug_interrupted_in(dbg),
    .insn_retire_in(ret), .exc_ready_out(rdy), .status_word_out(sr_o), .system_stack_pointer_out(ssp_o),
    .handler_pc_out(hpc), .handler_fetch_out(hf), .irq_inhibit_out(inh), .mem_req_out(mreq),
    .mem_we_out(mwe), .interrupt_acknowledge_cycle_out(mcyc), .mem_addr_out(maddr), .mem_wdata_out(mwd),
    .mem_ack_in(ack), .mem_autovec_in(av), .mem_err_in(merr), .mem_rdata_in(mrd)
  );

  efvu_mem_model i_efvu_mem_model (
    .clk_in(clk), .rst_n_in(rst_n), .req_in(mreq), .we_in(mwe), .ack_cyc_in(mcyc), .addr_in(maddr),
    .delay_in(dly), .mode_in(md), .vec_in(mvec), .ack_out(ack), .autovec_out(av), .err_out(merr),
    .rdata_out(mrd)
  );

  // ----
  // Bus recorder and hang guard
  // ----
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mreq && (ack || merr)) begin
      if (mwe) begin
        wa[1] <= wa[0];
        wa[0] <= maddr;
        wdv[1] <= wdv[0];
        wdv[0] <= mwd;
      end else if (mcyc) begin
        ia <= maddr;
      end else begin
        ra <= maddr;
      end
    end
    if (cyc == 8000) begin
      err_total = err_total + 1;
      give_verdict();
    end
  end

  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge clk);
      if (awv && awr) aw_ok = 1'b1;
      if (wv && wrd) w_ok = 1'b1;
      @(posedge clk);
      if (aw_ok) awv <= 1'b0;
      if (w_ok) wv <= 1'b0;
    end
    do @(negedge clk); while (!bv);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge clk);
    brd <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (!rv);
    chk("rdata", ed, rdat);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge clk);
    rrd <= 1'b0;
  endtask

  task automatic exc(input logic i, input logic [7:0] v, input logic [2:0] l, input logic [1:0] m,
                     input logic [31:0] s, input logic [3:0] f, input logic d);
    logic [7:0] ev;
    logic [3:0] ef;
    logic [15:0] es;
    logic [31:0] sp8;
    ev = !i ? v : (m == 2'h1 ? 8'h18 + {5'h00, l} : (m == 2'h2 ? VEC_SPURIOUS : v));
    ef = ((ev == VEC_ACCESS || ev == VEC_ADDRESS || d) && f inside {4'h0, 4'h4, 4'h8, 4'h9, 4'hC}) ? f : 4'h0;
    es = sr;
    es[SR_TRACE] = 1'b0;
    es[SR_SUPER] = 1'b1;
    es[11] = 1'b0;
    if (i) begin
      es[SR_MASTER] = 1'b0;
      es[10:8] = l;
    end
    sp8 = {s[31:2], 2'h0} - 32'h0000_0008;
    @(posedge clk);
    req <= 1'b1;
    isi <= i;
    vec <= v;
    mvec <= v;
    lvl <= l;
    md <= m;
    ssp <= s;
    fs <= f;
    dbg <= d;
    dly <= dly + 2'h1;
    do @(negedge clk); while (!rdy);
    @(posedge clk);
    req <= 1'b0;
    do @(negedge clk); while (!hf);
    chk("sp", sp8, ssp_o);
    chk("sr", {16'h0, es}, {16'h0, sr_o});
    chk("pc_addr", sp8 + 32'h0000_0004, wa[1]);
    chk("pc", (!i && ev inside {2, 3, 4, 5, 8, 10, 11, 14, 61}) ? fpc : npc, wdv[1]);
    chk("fv_addr", sp8, wa[0]);
    chk("fv", {2'h1, s[1:0], ef[3:2], ev, ef[1:0], sr}, wdv[0]);
    chk("table", {vbr[31:20], 10'h000, ev, 2'h0}, ra);
    chk("handler", ~{vbr[31:20], 10'h000, ev, 2'h0}, hpc);
    if (i) chk("ack_addr", {27'h7FF_FFFF, l, 2'h0}, ia);
    @(negedge clk);
    chk("inhibit", 32'h1, {31'h0, inh});
    chk("ready", {31'h0, !i}, {31'h0, rdy});
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    @(negedge clk);
    chk("inhibit", 32'h0, {31'h0, inh});
  endtask

  task automatic give_verdict();
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_VBR, VBR_RST, RESP_OKAY);
    rd(ADDR_CTRL, {31'h0, CTRL_EN_RST}, RESP_OKAY);
    rd(ADDR_IMASK, {29'h0, IMASK_RST}, RESP_OKAY);
    rd(8'h14, 32'h0000_0000, RESP_SLVERR);
    wr(8'h14, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(ADDR_VBR, 32'h1234_5678, RESP_OKAY);
    vbr = 32'h1230_0000;
    rd(ADDR_VBR, vbr, RESP_OKAY);
    ws <= 4'h4;
    wr(ADDR_VBR, 32'hABCD_EF01, RESP_OKAY);
    ws <= 4'hF;
    vbr = 32'h12C0_0000;
    rd(ADDR_VBR, vbr, RESP_OKAY);
    wr(ADDR_IMASK, 32'h0000_0007, RESP_OKAY);
    for (int i = 0; i < 20; i++) begin
      exc(1'b0, VL[i], 3'h0, 2'h0, 32'h0000_8000 + 32'(i), FSL[i % 5], i[3]);
    end
    for (int l = 1; l < 8; l++) begin
      for (int m = 0; m < 3; m++) begin
        exc(1'b1, {3'h4, 3'(l), 2'(m)}, 3'(l), 2'(m), 32'h0001_0000 + 32'(m), 4'h0, 1'b0);
      end
    end
    chk("irq", 32'h1, {31'h0, irq});
    rd(ADDR_ISTS, 32'h0000_0007, RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
    wr(ADDR_IMASK, 32'h0000_0000, RESP_OKAY);
    exc(1'b0, VEC_TRAP_LO, 3'h0, 2'h0, 32'h0000_4003, 4'h0, 1'b0);
    chk("irq", 32'h0, {31'h0, irq});
    rd(ADDR_ISTS, 32'h0000_0001, RESP_OKAY);
    rd(ADDR_LAST, {20'h0, 4'h7, VEC_TRAP_LO}, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    @(posedge clk);
    req <= 1'b1;
    repeat (3) @(negedge clk);
    chk("ready", 32'h0, {31'h0, rdy});
    chk("mem_req", 32'h0, {31'h0, mreq});
    @(posedge clk);
    req <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    exc(1'b1, 8'hFF, 3'h7, 2'h0, 32'h0000_0102, 4'h0, 1'b0);
    give_verdict();
  end
endmodule
